// ===== logic/obc_consts.vh
/*
 Shared constants of the opportunistic boost control block: register
 addresses, field positions, reset values and capability query codes.
 Assumes it is included by bare name from the logic/ design files.
*/
`ifndef OBC_CONSTS_VH
`define OBC_CONSTS_VH

// Model-specific register addresses
`define OBC_ADDR_FIXED_REF 32'h000000e7
`define OBC_ADDR_ACTUAL 32'h000000e8
`define OBC_ADDR_STATUS 32'h00000198
`define OBC_ADDR_CTL 32'h00000199
`define OBC_ADDR_MISC 32'h000001f0

// Field positions
`define OBC_MISC_BOOST_DIS_BIT 38
`define OBC_CTL_DISENGAGE_BIT 32
`define OBC_RATIO_LSB 0
`define OBC_RATIO_W 8
`define OBC_CQ_EAX_BOOST_BIT 1

// Reset values
`define OBC_CTL_RST 64'h0000000000000000
`define OBC_CNT_RST 64'h0000000000000000
`define OBC_MISC_RST_LOW 38'h0000000000
`define OBC_MISC_RST_HIGH 25'h0000000

// Capability query leaf for power management
`define OBC_CQ_LEAF_PM 32'h00000006

`endif

// ===== logic/obc_sync.v
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes the inputs are slow levels from outside the clock domain.
*/
`timescale 1ns/1ps
module obc_sync #(
    parameter W = 2
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Levels
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage is read only by the second stage
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // obc_sync

// ===== logic/obc_clamp.v
/*
 Operating ratio selector of one logical processor: limits the target
 ratio to the non-boost ceiling unless boost is granted, and registers it.
 Assumes grant and target come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "obc_consts.vh"
module obc_clamp #(
    parameter [`OBC_RATIO_W-1:0] MAX_NB = 8'h10,
    parameter [`OBC_RATIO_W-1:0] MAX_BOOST = 8'h18
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Request
    input wire [`OBC_RATIO_W-1:0] target_i,
    input wire grant_i,
    // Result
    output wire [`OBC_RATIO_W-1:0] ratio_o
);
    reg [`OBC_RATIO_W-1:0] ratio_reg;
    reg [`OBC_RATIO_W-1:0] ratio_next;

    // Without a grant the ceiling is the highest non-boost point
    always @* begin
        if (grant_i) begin
            ratio_next = (target_i > MAX_BOOST) ? MAX_BOOST : target_i;
        end else begin
            ratio_next = (target_i > MAX_NB) ? MAX_NB : target_i;
        end
    end

    // Starts at the lowest point until a target is written
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_reg <= {`OBC_RATIO_W{1'b0}};
        end else begin
            ratio_reg <= ratio_next;
        end
    end

    assign ratio_o = ratio_reg;
endmodule // obc_clamp

// ===== logic/obc_top.v
/*
 Opportunistic boost control: package enable bit, per logical processor
 performance target and disengage bit, status, feedback counters and the
 capability query answer.
 Assumes register and query requests are one-cycle pulses from logic on
 the same clock; headroom and criteria levels arrive asynchronously.
*/
// What this block does
// - Supporting device: enable bit resets to one
// - Unsupported device: enable bit resets to zero
// - One enable bit shared by whole package
// - Bit set disables boost; clear enables it
// - Query leaf 06H bit 1 reports enabled
// - Enable bit set forces query bit zero
// - Control bit 32 disengages; clearing re-engages
// - Status bit 32 never mirrors disengage
// - Disengage bit private to each processor
// - Boost only when enabled, headroom, criteria
// - Actual over reference exceeds one when boosted
// - Single core may boost on OS request
// - Reference fixed rate; actual tracks delivered performance
// - Any counter overflow zeroes both counters
`timescale 1ns/1ps
`include "obc_consts.vh"
module obc_top #(
    parameter NUM_LP = 2,
    parameter LPW = 1,
    parameter BOOST_SUPPORTED = 1,
    parameter SINGLE_CORE = 1,
    parameter [`OBC_RATIO_W-1:0] BASE_RATIO = 8'h10,
    parameter [`OBC_RATIO_W-1:0] MAX_NB = 8'h10,
    parameter [`OBC_RATIO_W-1:0] MAX_BOOST = 8'h18
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // Model register access
    input wire mr_rd_i,
    input wire mr_wr_i,
    input wire [LPW-1:0] mr_lp_i,
    input wire [31:0] mr_addr_i,
    input wire [63:0] mr_wdata_i,
    output wire mr_done_o,
    output wire mr_fault_o,
    output wire [63:0] mr_rdata_o,
    // Capability query
    input wire cq_req_i,
    input wire [31:0] cq_leaf_i,
    output wire cq_valid_o,
    output wire [31:0] cq_eax_o,
    // Per logical processor activity, same clock
    input wire [NUM_LP-1:0] ref_tick_i,
    input wire [NUM_LP-1:0] active_i,
    // Thermal and internal conditions, asynchronous
    input wire headroom_i,
    input wire criteria_i,
    // Operating point
    output wire [NUM_LP*`OBC_RATIO_W-1:0] op_ratio_o,
    output wire [NUM_LP-1:0] boost_active_o,
    output wire boost_enabled_o
);
    localparam RW = `OBC_RATIO_W;
    localparam [0:0] SUP_BIT = (BOOST_SUPPORTED != 0);

    // Lowest set bit as one-hot, used for the single core grant
    function [NUM_LP-1:0] obc_lowest;
        input [NUM_LP-1:0] v;
        integer k;
        reg found;
        begin
            obc_lowest = {NUM_LP{1'b0}};
            found = 1'b0;
            for (k = 0; k < NUM_LP; k = k + 1) begin
                if (v[k] && !found) begin
                    obc_lowest[k] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Address match, shared by read and write decode
    function is_addr;
        input [31:0] a;
        input [31:0] ref_a;
        begin
            is_addr = (a == ref_a);
        end
    endfunction

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;
    wire [1:0] cond_s;
    wire boost_ok;
    reg [63:0] misc_reg;
    wire boost_en;
    reg [63:0] ctl_reg [0:NUM_LP-1];
    reg [63:0] fix_reg [0:NUM_LP-1];
    reg [63:0] act_reg [0:NUM_LP-1];
    wire [NUM_LP-1:0] boost_req;
    reg [NUM_LP-1:0] grant;
    wire [NUM_LP*RW-1:0] ratio_flat;
    wire hit_fix;
    wire hit_act;
    wire hit_stat;
    wire hit_ctl;
    wire hit_misc;
    wire wr_ok;
    reg [63:0] rdata_next;
    reg rd_fault_next;
    reg done_reg;
    reg fault_reg;
    reg [63:0] rdata_reg;
    reg cq_valid_reg;
    reg [31:0] cq_eax_reg;
    reg [NUM_LP-1:0] boost_act_reg;
    reg boost_en_reg;

    // Reset asserts at once and releases after two edges
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Headroom and criteria come from the thermal side
    obc_sync #(
        .W(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .async_i({criteria_i, headroom_i}),
        .sync_o(cond_s)
    );

    // Register address decode
    assign hit_fix = is_addr(mr_addr_i, `OBC_ADDR_FIXED_REF);
    assign hit_act = is_addr(mr_addr_i, `OBC_ADDR_ACTUAL);
    assign hit_stat = is_addr(mr_addr_i, `OBC_ADDR_STATUS);
    assign hit_ctl = is_addr(mr_addr_i, `OBC_ADDR_CTL);
    assign hit_misc = is_addr(mr_addr_i, `OBC_ADDR_MISC);
    // Status is read only, so a write to it faults
    assign wr_ok = hit_fix | hit_act | hit_ctl | hit_misc;

    // One package-wide copy; any processor's write reaches all of them
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            misc_reg <= {`OBC_MISC_RST_HIGH, SUP_BIT,
                `OBC_MISC_RST_LOW};
        end else if (mr_wr_i && hit_misc) begin
            misc_reg <= mr_wdata_i;
        end
    end

    // Bit set means disabled; unsupported parts never enable
    assign boost_en = SUP_BIT &
        ~misc_reg[`OBC_MISC_BOOST_DIS_BIT];
    // Entry is opportunistic: all three conditions are needed
    assign boost_ok = boost_en & cond_s[0] & cond_s[1];

    // Per processor control and feedback counters
    genvar g;
    generate
        for (g = 0; g < NUM_LP; g = g + 1) begin : g_lp
            wire sel;
            wire [RW-1:0] target;
            wire [RW-1:0] ratio;
            wire [64:0] fix_sum;
            wire [64:0] act_sum;
            wire [RW-1:0] act_step;
            wire ovf;
            localparam [LPW-1:0] LP_ID = g;

            assign sel = (mr_lp_i == LP_ID);
            assign target = ctl_reg[g][`OBC_RATIO_LSB +: RW];
            assign ratio = ratio_flat[g*RW +: RW];
            // Disengage is private to this processor
            assign boost_req[g] = ~ctl_reg[g][`OBC_CTL_DISENGAGE_BIT] &
                (target > MAX_NB);

            // Whole word stored; software keeps other fields itself
            always @(posedge clk_sys_i or negedge rst_n) begin
                if (!rst_n) begin
                    ctl_reg[g] <= `OBC_CTL_RST;
                end else if (mr_wr_i && hit_ctl && sel) begin
                    ctl_reg[g] <= mr_wdata_i;
                end
            end

            // Reference steps by the base ratio, actual by the
            // delivered ratio, so a boosted window reads above one
            assign fix_sum = {1'b0, fix_reg[g]} +
                {{(65-RW){1'b0}}, BASE_RATIO};
            assign act_step = active_i[g] ? ratio : {RW{1'b0}};
            assign act_sum = {1'b0, act_reg[g]} +
                {{(65-RW){1'b0}}, act_step};
            assign ovf = ref_tick_i[g] & (fix_sum[64] | act_sum[64]);

            // A software write wins over counting and overflow
            always @(posedge clk_sys_i or negedge rst_n) begin
                if (!rst_n) begin
                    fix_reg[g] <= `OBC_CNT_RST;
                    act_reg[g] <= `OBC_CNT_RST;
                end else begin
                    if (mr_wr_i && hit_fix && sel) begin
                        fix_reg[g] <= mr_wdata_i;
                    end else if (ovf) begin
                        fix_reg[g] <= `OBC_CNT_RST;
                    end else if (ref_tick_i[g]) begin
                        fix_reg[g] <= fix_sum[63:0];
                    end
                    if (mr_wr_i && hit_act && sel) begin
                        act_reg[g] <= mr_wdata_i;
                    end else if (ovf) begin
                        act_reg[g] <= `OBC_CNT_RST;
                    end else if (ref_tick_i[g]) begin
                        act_reg[g] <= act_sum[63:0];
                    end
                end
            end

            obc_clamp #(
                .MAX_NB(MAX_NB),
                .MAX_BOOST(MAX_BOOST)
            ) u_clamp (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n),
                .target_i(target),
                .grant_i(grant[g]),
                .ratio_o(ratio_flat[g*RW +: RW])
            );
        end
    endgenerate

    // Grant boost; in single core mode only one processor at a time
    always @* begin
        if (!boost_ok) begin
            grant = {NUM_LP{1'b0}};
        end else if (SINGLE_CORE != 0) begin
            grant = obc_lowest(boost_req);
        end else begin
            grant = boost_req;
        end
    end

    // Read data selection for the addressed processor
    always @* begin
        rdata_next = 64'h0000000000000000;
        rd_fault_next = 1'b0;
        if (hit_fix) begin
            rdata_next = fix_reg[mr_lp_i];
        end else if (hit_act) begin
            rdata_next = act_reg[mr_lp_i];
        end else if (hit_ctl) begin
            rdata_next = ctl_reg[mr_lp_i];
        end else if (hit_misc) begin
            rdata_next = misc_reg;
        end else if (hit_stat) begin
            // Bit 32 and up stay zero whatever disengage holds
            rdata_next = {{(64-RW){1'b0}},
                ratio_flat[mr_lp_i*RW +: RW]};
        end else begin
            rd_fault_next = 1'b1;
        end
    end

    // Answer one cycle after the request; a write takes precedence
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
            rdata_reg <= 64'h0000000000000000;
        end else begin
            done_reg <= mr_rd_i | mr_wr_i;
            if (mr_wr_i) begin
                fault_reg <= ~wr_ok;
                rdata_reg <= 64'h0000000000000000;
            end else if (mr_rd_i) begin
                fault_reg <= rd_fault_next;
                rdata_reg <= rdata_next;
            end else begin
                fault_reg <= 1'b0;
            end
        end
    end

    // Capability query: leaf 06H bit 1 shows the enabled state
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cq_valid_reg <= 1'b0;
            cq_eax_reg <= 32'h00000000;
        end else begin
            cq_valid_reg <= cq_req_i;
            if (cq_req_i) begin
                cq_eax_reg <= 32'h00000000;
                if (cq_leaf_i == `OBC_CQ_LEAF_PM) begin
                    // Zero whenever the disable bit is set
                    cq_eax_reg[`OBC_CQ_EAX_BOOST_BIT] <=
                        boost_en;
                end
            end
        end
    end

    // Registered view of who is boosting and whether boost is on
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            boost_act_reg <= {NUM_LP{1'b0}};
            boost_en_reg <= 1'b0;
        end else begin
            boost_act_reg <= grant;
            boost_en_reg <= boost_en;
        end
    end

    assign mr_done_o = done_reg;
    assign mr_fault_o = fault_reg;
    assign mr_rdata_o = rdata_reg;
    assign cq_valid_o = cq_valid_reg;
    assign cq_eax_o = cq_eax_reg;
    assign op_ratio_o = ratio_flat;
    assign boost_active_o = boost_act_reg;
    assign boost_enabled_o = boost_en_reg;
endmodule // obc_top

// ===== tb/obc_top_monitor.sv
/*
 Port checker of the boost control block.
 Assumes it is bound onto every obc_top instance.
*/
`timescale 1ns/1ps
module obc_top_monitor #(
    parameter NUM_LP = 2,
    parameter SINGLE_CORE = 1,
    parameter [7:0] MAX_NB = 8'h10,
    parameter [7:0] MAX_BOOST = 8'h18
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // Register access
    input wire mr_rd_i,
    input wire mr_wr_i,
    input wire [31:0] mr_addr_i,
    input wire mr_done_o,
    input wire mr_fault_o,
    input wire [63:0] mr_rdata_o,
    // Query and operating point
    input wire cq_req_i,
    input wire [31:0] cq_leaf_i,
    input wire cq_valid_o,
    input wire [31:0] cq_eax_o,
    input wire [NUM_LP*8-1:0] op_ratio_o,
    input wire [NUM_LP-1:0] boost_active_o,
    input wire boost_enabled_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Bus answers come exactly one cycle after the request
    reg_answer_a: assert property ((mr_rd_i || mr_wr_i) |=> mr_done_o)
        else $error("register request without answer");
    stray_done_a: assert property (mr_done_o |-> $past(mr_rd_i || mr_wr_i))
        else $error("answer without request");
    fault_done_a: assert property (mr_fault_o |-> mr_done_o)
        else $error("fault outside answer");
    status_ro_a: assert property (
        (mr_wr_i && mr_addr_i == 32'h198) |=> mr_fault_o)
        else $error("status write not refused");
    status_bit_a: assert property (
        (mr_rd_i && !mr_wr_i && mr_addr_i == 32'h198)
        |=> mr_rdata_o[63:8] == 56'h0)
        else $error("status upper bits not zero");
    // Query bit must equal the enable state seen at the request edge
    query_bit_a: assert property ((cq_req_i && cq_leaf_i == 32'h6)
        |=> cq_valid_o && cq_eax_o[1] == boost_enabled_o
        && cq_eax_o[0] == 1'b0)
        else $error("query bit wrong");
    query_leaf_a: assert property (
        (cq_req_i && cq_leaf_i != 32'h6) |=> cq_eax_o == 32'h0)
        else $error("other leaf not zero");
    one_core_a: assert property (
        (SINGLE_CORE != 0) |-> $onehot0(boost_active_o))
        else $error("more than one core boosted");
    dis_clamp_a: assert property (
        !boost_enabled_o [*3] |-> op_ratio_o[7:0] <= MAX_NB)
        else $error("boost ratio while disabled");
    boost_ratio_a: assert property (boost_active_o[0] |->
        op_ratio_o[7:0] > MAX_NB && op_ratio_o[7:0] <= MAX_BOOST)
        else $error("boost ratio out of range");
    ratio_ceil_a: assert property (op_ratio_o[7:0] <= MAX_BOOST)
        else $error("ratio above boost ceiling");
    // Main scenarios
    boost_c: cover property ($rose(boost_active_o[0]));
    fault_c: cover property (mr_fault_o);
    query_c: cover property (cq_valid_o && cq_eax_o[1]);
endmodule // obc_top_monitor

bind obc_top obc_top_monitor #(.NUM_LP(NUM_LP), .SINGLE_CORE(SINGLE_CORE),
    .MAX_NB(MAX_NB), .MAX_BOOST(MAX_BOOST)) obc_top_monitor_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .mr_rd_i(mr_rd_i),
    .mr_wr_i(mr_wr_i), .mr_addr_i(mr_addr_i), .mr_done_o(mr_done_o),
    .mr_fault_o(mr_fault_o), .mr_rdata_o(mr_rdata_o), .cq_req_i(cq_req_i),
    .cq_leaf_i(cq_leaf_i), .cq_valid_o(cq_valid_o), .cq_eax_o(cq_eax_o),
    .op_ratio_o(op_ratio_o), .boost_active_o(boost_active_o),
    .boost_enabled_o(boost_enabled_o));

// ===== tb/obc_top_tb_top.sv
/*
 Testbench of the boost control block; a register model checks answers.
 Assumes the logic/ files and the bound checker.
*/
`timescale 1ns/1ps
module obc_top_tb_top;
    reg clk_sys_i = 1'b0;
    reg nrst_i = 1'b0;
    reg mr_rd_i = 1'b0;
    reg mr_wr_i = 1'b0;
    reg [0:0] mr_lp_i = 1'b0;
    reg [31:0] mr_addr_i = 32'h0;
    reg [63:0] mr_wdata_i = 64'h0;
    reg cq_req_i = 1'b0;
    reg [31:0] cq_leaf_i = 32'h0;
    reg [1:0] ref_tick_i = 2'h0;
    reg [1:0] active_i = 2'h0;
    reg headroom_i = 1'b0;
    reg criteria_i = 1'b0;
    wire mr_done_o, mr_fault_o, cq_valid_o, boost_enabled_o, ns_en;
    wire [63:0] mr_rdata_o, ns_rdata;
    wire [31:0] cq_eax_o;
    wire [15:0] op_ratio_o;
    wire [1:0] boost_active_o;
    wire [15:0] mc_ratio;
    wire [1:0] mc_act;
    reg [63:0] misc_m, v;
    reg [63:0] ctl_m [0:1];
    reg [31:0] seed = 32'hd;
    integer num_errors = 0;
    integer check_count = 0;
    integer cycles = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    obc_top obc_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .mr_rd_i(mr_rd_i), .mr_wr_i(mr_wr_i), .mr_lp_i(mr_lp_i),
        .mr_addr_i(mr_addr_i), .mr_wdata_i(mr_wdata_i),
        .mr_done_o(mr_done_o), .mr_fault_o(mr_fault_o),
        .mr_rdata_o(mr_rdata_o), .cq_req_i(cq_req_i),
        .cq_leaf_i(cq_leaf_i), .cq_valid_o(cq_valid_o),
        .cq_eax_o(cq_eax_o), .ref_tick_i(ref_tick_i), .active_i(active_i),
        .headroom_i(headroom_i), .criteria_i(criteria_i),
        .op_ratio_o(op_ratio_o), .boost_active_o(boost_active_o),
        .boost_enabled_o(boost_enabled_o));
    // Twin without boost hardware, fed the same stimulus
    obc_top #(.BOOST_SUPPORTED(0)) obc_top_ns_i (.clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i), .mr_rd_i(mr_rd_i), .mr_wr_i(mr_wr_i),
        .mr_lp_i(mr_lp_i), .mr_addr_i(mr_addr_i), .mr_wdata_i(mr_wdata_i),
        .mr_done_o(), .mr_fault_o(), .mr_rdata_o(ns_rdata),
        .cq_req_i(cq_req_i), .cq_leaf_i(cq_leaf_i), .cq_valid_o(),
        .cq_eax_o(), .ref_tick_i(ref_tick_i), .active_i(active_i),
        .headroom_i(headroom_i), .criteria_i(criteria_i), .op_ratio_o(),
        .boost_active_o(), .boost_enabled_o(ns_en));
    // Twin in all-cores mode: every requester may boost at once
    obc_top #(.SINGLE_CORE(0)) obc_top_mc_i (.clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i), .mr_rd_i(mr_rd_i), .mr_wr_i(mr_wr_i),
        .mr_lp_i(mr_lp_i), .mr_addr_i(mr_addr_i), .mr_wdata_i(mr_wdata_i),
        .mr_done_o(), .mr_fault_o(), .mr_rdata_o(), .cq_req_i(cq_req_i),
        .cq_leaf_i(cq_leaf_i), .cq_valid_o(), .cq_eax_o(),
        .ref_tick_i(ref_tick_i), .active_i(active_i),
        .headroom_i(headroom_i), .criteria_i(criteria_i),
        .op_ratio_o(mc_ratio), .boost_active_o(mc_act),
        .boost_enabled_o());

    task rnd(output [63:0] r);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            r = {seed, ~seed};
        end
    endtask

    task chk(input [63:0] seen, input [63:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // One access; done and fault stand one cycle, so look right away
    task acc(input wr, input lp, input [31:0] a, input [63:0] d, input f);
        begin
            @(posedge clk_sys_i);
            mr_wr_i <= wr;
            mr_rd_i <= !wr;
            mr_lp_i <= lp;
            mr_addr_i <= a;
            mr_wdata_i <= d;
            @(posedge clk_sys_i);
            mr_wr_i <= 1'b0;
            mr_rd_i <= 1'b0;
            #1;
            chk({mr_done_o, mr_fault_o}, {1'b1, f});
        end
    endtask

    task q(input [31:0] leaf);
        begin
            @(posedge clk_sys_i);
            cq_req_i <= 1'b1;
            cq_leaf_i <= leaf;
            @(posedge clk_sys_i);
            cq_req_i <= 1'b0;
            #1;
            chk(cq_valid_o, 1'b1);
        end
    endtask

    // Ratio changes cross the input synchronisers, so allow them to settle
    task op(input [15:0] r, input [1:0] b);
        begin
            repeat (8) @(posedge clk_sys_i);
            #1;
            chk({op_ratio_o, boost_active_o}, {r, b});
        end
    endtask

    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        misc_m = 64'h40_0000_0000;
        ctl_m[0] = 64'h0;
        ctl_m[1] = 64'h0;
        acc(0, 0, 32'h1f0, 64'h0, 0);
        chk(mr_rdata_o, misc_m);
        chk(ns_rdata[38], 1'b0);
        acc(0, 1, 32'h199, 64'h0, 0);
        chk(mr_rdata_o, ctl_m[1]);
        q(32'h6);
        chk(cq_eax_o, 32'h0);
        $display("test reset values done");
        // Firmware enables from one processor, another reads it back
        rnd(misc_m);
        misc_m[38] = 1'b0;
        acc(1, 1, 32'h1f0, misc_m, 0);
        acc(0, 0, 32'h1f0, 64'h0, 0);
        chk(mr_rdata_o, misc_m);
        chk({boost_enabled_o, ns_en}, 2'b10);
        q(32'h6);
        chk(cq_eax_o, 32'h2);
        q(32'h7);
        chk(cq_eax_o, 32'h0);
        misc_m[38] = 1'b1;
        acc(1, 0, 32'h1f0, misc_m, 0);
        q(32'h6);
        chk({cq_eax_o, boost_enabled_o}, 33'h0);
        misc_m[38] = 1'b0;
        acc(1, 0, 32'h1f0, misc_m, 0);
        $display("test enable done");
        // Both processors ask for boost; only the lower one gets it
        headroom_i <= 1'b1;
        criteria_i <= 1'b1;
        rnd(ctl_m[0]);
        rnd(ctl_m[1]);
        ctl_m[0][32] = 1'b0;
        ctl_m[1][32] = 1'b0;
        ctl_m[0][7:0] = 8'h20;
        ctl_m[1][7:0] = 8'h20;
        acc(1, 1, 32'h199, ctl_m[1], 0);
        acc(1, 0, 32'h199, ctl_m[0], 0);
        op(16'h1018, 2'b01);
        chk({mc_ratio, mc_act}, {16'h1818, 2'b11});
        acc(0, 0, 32'h199, 64'h0, 0);
        chk(mr_rdata_o, ctl_m[0]);
        ctl_m[0][32] = 1'b1;
        acc(1, 0, 32'h199, ctl_m[0], 0);
        op(16'h1810, 2'b10);
        acc(0, 0, 32'h198, 64'h0, 0);
        chk(mr_rdata_o, 64'h10);
        acc(0, 1, 32'h199, 64'h0, 0);
        chk(mr_rdata_o, ctl_m[1]);
        ctl_m[0][32] = 1'b0;
        acc(1, 0, 32'h199, ctl_m[0], 0);
        op(16'h1018, 2'b01);
        headroom_i <= 1'b0;
        op(16'h1010, 2'b00);
        headroom_i <= 1'b1;
        op(16'h1018, 2'b01);
        $display("test disengage done");
        // Feedback counters over a boosted window
        active_i <= 2'b11;
        acc(1, 0, 32'he7, 64'h0, 0);
        acc(1, 0, 32'he8, 64'h0, 0);
        @(posedge clk_sys_i);
        ref_tick_i <= 2'b01;
        repeat (20) @(posedge clk_sys_i);
        ref_tick_i <= 2'b00;
        acc(0, 0, 32'he7, 64'h0, 0);
        chk(mr_rdata_o, 64'd320);
        v = mr_rdata_o;
        acc(0, 0, 32'he8, 64'h0, 0);
        chk(mr_rdata_o, 64'd480);
        chk(mr_rdata_o > v, 1'b1);
        acc(0, 1, 32'he7, 64'h0, 0);
        chk(mr_rdata_o, 64'h0);
        acc(1, 0, 32'he7, 64'hffff_ffff_ffff_fff8, 0);
        @(posedge clk_sys_i);
        ref_tick_i <= 2'b01;
        @(posedge clk_sys_i);
        ref_tick_i <= 2'b00;
        acc(0, 0, 32'he7, 64'h0, 0);
        chk(mr_rdata_o, 64'h0);
        acc(0, 0, 32'he8, 64'h0, 0);
        chk(mr_rdata_o, 64'h0);
        // An idle processor keeps its actual count still
        @(posedge clk_sys_i);
        active_i <= 2'b10;
        ref_tick_i <= 2'b01;
        repeat (4) @(posedge clk_sys_i);
        ref_tick_i <= 2'b00;
        acc(0, 0, 32'he7, 64'h0, 0);
        chk(mr_rdata_o, 64'd64);
        acc(0, 0, 32'he8, 64'h0, 0);
        chk(mr_rdata_o, 64'h0);
        $display("test counters done");
        // Refused accesses leave state alone
        acc(0, 0, 32'h2a0, 64'h0, 1);
        chk(mr_rdata_o, 64'h0);
        rnd(v);
        acc(1, 0, 32'h198, v, 1);
        acc(0, 0, 32'h198, 64'h0, 0);
        chk(mr_rdata_o, 64'h18);
        $display("test refusals done");
        // Disabling from processor 1 pulls the boosted processor 0 back
        misc_m[38] = 1'b1;
        acc(1, 1, 32'h1f0, misc_m, 0);
        op(16'h1010, 2'b00);
        q(32'h6);
        chk(cq_eax_o, 32'h0);
        $display("test late disable done");
        wrap_up;
    end
endmodule // obc_top_tb_top
